// ===== design/uart_cfg_pkg.sv
// Register map, field layout and reset values of the serial port block
package uart_cfg_pkg;
  // Register byte offsets
  localparam logic [7:0]  OFS_PORT_STATUS   = 8'h00;
  localparam logic [7:0]  OFS_FRAME_CFG     = 8'h04;
  localparam logic [7:0]  OFS_THRESH_CFG    = 8'h08;
  localparam logic [7:0]  OFS_LOW_PULSE     = 8'h0C;
  localparam logic [7:0]  OFS_DATA          = 8'h10;
  localparam logic [7:0]  OFS_EVENT_STATUS  = 8'h14;
  localparam logic [7:0]  OFS_BAUD_DIV      = 8'h18;
  localparam int          ADDR_LSB_W        = 8;
  // Port status fields
  localparam int          ST_RTS            = 30;
  localparam int          ST_DTR            = 29;
  localparam int          ST_TXCNT_LO       = 16;
  localparam int          ST_RXD            = 15;
  localparam int          ST_CTS            = 14;
  localparam int          ST_DSR            = 13;
  localparam int          ST_RXCNT_LO       = 0;
  // Frame and line configuration fields
  localparam int          FC_DTR_INV        = 24;
  localparam int          FC_RTS_INV        = 23;
  localparam int          FC_TXD_INV        = 22;
  localparam int          FC_DSR_INV        = 21;
  localparam int          FC_CTS_INV        = 20;
  localparam int          FC_RXD_INV        = 19;
  localparam int          FC_TXFIFO_RST     = 18;
  localparam int          FC_RXFIFO_RST     = 17;
  localparam int          FC_RESERVED       = 16;
  localparam int          FC_TX_FLOW_EN     = 15;
  localparam int          FC_LOOPBACK       = 14;
  localparam int          FC_TX_BREAK       = 8;
  localparam int          FC_SW_DTR         = 7;
  localparam int          FC_SW_REQ         = 6;
  localparam int          FC_STOP_LO        = 4;
  localparam int          FC_LEN_LO         = 2;
  localparam int          FC_PARITY_EN      = 1;
  localparam int          FC_PARITY_ODD     = 0;
  localparam logic [31:0] FC_RESET          = 32'h0000_0010;
  localparam logic [31:0] FC_MASK           = 32'h01FF_C1FF;
  // Threshold configuration fields
  localparam int          TC_TOUT_EN        = 31;
  localparam int          TC_TOUT_LO        = 24;
  localparam int          TC_RX_FLOW_EN     = 23;
  localparam int          TC_FLOW_LO        = 16;
  localparam int          TC_TX_EMPTY_LO    = 8;
  localparam int          TC_RX_FULL_LO     = 0;
  localparam logic [31:0] TC_RESET          = 32'h0000_6060;
  localparam logic [31:0] TC_MASK           = 32'hFFFF_7F7F;
  // Event status bits
  localparam int          EV_TX_LOW         = 0;
  localparam int          EV_RX_HIGH        = 1;
  localparam int          EV_TIMEOUT        = 2;
  localparam int          EV_PARITY_ERR     = 3;
  localparam int          EV_FRAME_ERR      = 4;
  localparam int          EV_RX_OVERRUN     = 5;
  // Stop length codes
  localparam logic [1:0]  STOP_ONE_HALF     = 2'h2;
  localparam logic [1:0]  STOP_TWO          = 2'h3;
  localparam logic [2:0]  HALVES_ONE        = 3'h2;
  localparam logic [2:0]  HALVES_ONE_HALF   = 3'h3;
  localparam logic [2:0]  HALVES_TWO        = 3'h4;
  // Misc constants
  localparam logic [3:0]  MIN_DATA_BITS     = 4'h5;
  localparam logic [3:0]  CHAR_BITS         = 4'hA;
  localparam logic [19:0] LOW_PULSE_RESET   = 20'hF_FFFF;
  localparam logic [15:0] BAUD_DIV_RESET    = 16'h0057;
  localparam logic [15:0] BAUD_DIV_MIN      = 16'h0002;
  localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
  // One-hot frame states shared by both directions
  typedef enum logic [4:0] {
    FR_IDLE   = 5'b00001,
    FR_START  = 5'b00010,
    FR_DATA   = 5'b00100,
    FR_PARITY = 5'b01000,
    FR_STOP   = 5'b10000
  } frame_state_e;
endpackage : uart_cfg_pkg

// ===== design/uart_frame_config_status.sv
// Serial port: frame config, line status, FIFOs, flow control, AHB-Lite registers
// Summary of operation
// - Both port instances share one identical config field layout.
// - Stop code 1 gives one stop bit, 2 gives one and half, 3 two.
// - Length code 0..3 gives five to eight data bits.
// - Parity enable adds parity on transmit and checks it on receive.
// - Parity select 0 is even parity, 1 is odd parity.
// - Each line invert bit except the DSR one flips its line between pin and logic; the DSR invert bit has no effect.
// - Loopback routes transmitted data back into own receiver.
// - Receive FIFO reset bit empties receive FIFO, count to zero.
// - Transmit FIFO reset bit empties transmit FIFO, count to zero.
// - Transmit flow control pauses new characters while clear-to-send deasserted.
// - Time-out enable flags time-out when line idles past threshold with data.
// - Time-out threshold counts character times, zero to 127.
// - Transmit nearly empty when fill at or below its threshold.
// - Receive nearly full when fill at or above its threshold.
// - Status reports transmit FIFO entry count.
// - Status reports receive FIFO entry count.
// - Status shows levels of receive data and modem lines.
// - Software modem bits drive request-to-send and data-terminal-ready.
// - Shortest low pulse on receive line is measured and readable.
// - Receive flow control drops request-to-send at receive flow threshold.
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
module uart_frame_config_status #(
  parameter int DEPTH = 128,
  parameter int DW    = 8
) (
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_rstn,
  input  wire logic                     i_hsel,
  input  wire logic [31:0]              i_haddr,
  input  wire logic [1:0]               i_htrans,
  input  wire logic                     i_hwrite,
  input  wire logic [2:0]               i_hsize,
  input  wire logic [31:0]              i_hwdata,
  input  wire logic                     i_hready,
  output logic      [31:0]              o_hrdata,
  output logic                          o_hreadyout,
  output logic                          o_hresp,
  input  wire logic                     i_rxd,
  input  wire logic                     i_cts,
  input  wire logic                     i_dsr,
  output logic                          o_txd,
  output logic                          o_software_request_line,
  output logic                          o_dtr,
  output logic                          o_tx_nearly_empty,
  output logic                          o_rx_nearly_full,
  output logic                          o_rx_timeout
);
  import uart_cfg_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [31:0]   frame_cfg_reg;
  logic [31:0]   thresh_cfg_reg;
  logic [15:0]   baud_div_reg;
  logic [19:0]   low_min_reg;
  logic [5:0]    event_reg;
  logic          wr_pend_reg;
  logic [7:0]    wr_addr_reg;
  logic [1:0]    rxd_sync_reg, cts_sync_reg, dsr_sync_reg;
  logic [DW-1:0] txf_mem [DEPTH];
  logic [DW-1:0] rxf_mem [DEPTH];
  logic [AW-1:0] txf_wp_reg, txf_rp_reg, rxf_wp_reg, rxf_rp_reg;
  logic [AW:0]   txf_cnt_reg, rxf_cnt_reg;
  frame_state_e  tx_state_reg, rx_state_reg;
  logic [15:0]   tx_tmr_reg, rx_tmr_reg;
  logic [3:0]    tx_bit_reg, rx_bit_reg;
  logic [DW-1:0] tx_shift_reg, rx_shift_reg;
  logic          tx_line_reg;
  logic          rx_line_prev_reg;
  logic [19:0]   low_run_reg;
  logic [15:0]   idle_tmr_reg;
  logic [3:0]    idle_bit_reg;
  logic [6:0]    idle_char_reg;

  // Decoded configuration; same layout for every instance
  logic       cfg_txf_rst, cfg_rxf_rst, cfg_par_en, cfg_par_odd, cfg_loop;
  logic [1:0] cfg_stop;
  logic [3:0] cfg_nbits;
  logic [6:0] thr_tout, thr_flow, thr_tx_empty, thr_rx_full;
  assign cfg_txf_rst  = frame_cfg_reg[FC_TXFIFO_RST];
  assign cfg_rxf_rst  = frame_cfg_reg[FC_RXFIFO_RST];
  assign cfg_par_en   = frame_cfg_reg[FC_PARITY_EN];
  assign cfg_par_odd  = frame_cfg_reg[FC_PARITY_ODD];
  assign cfg_loop     = frame_cfg_reg[FC_LOOPBACK];
  assign cfg_stop     = frame_cfg_reg[FC_STOP_LO +: 2];
  assign cfg_nbits    = MIN_DATA_BITS + {2'b00, frame_cfg_reg[FC_LEN_LO +: 2]};
  assign thr_tout     = thresh_cfg_reg[TC_TOUT_LO +: 7];
  assign thr_flow     = thresh_cfg_reg[TC_FLOW_LO +: 7];
  assign thr_tx_empty = thresh_cfg_reg[TC_TX_EMPTY_LO +: 7];
  assign thr_rx_full  = thresh_cfg_reg[TC_RX_FULL_LO +: 7];

  // Bus address phase: zero-wait, always OKAY
  logic       addr_ok;
  logic [7:0] addr_ofs;
  assign addr_ok  = i_hsel && i_htrans == HTRANS_NONSEQ && i_hready;
  assign addr_ofs = i_haddr[ADDR_LSB_W-1:0];

  logic rd_pop, wr_now, tx_push;
  assign rd_pop  = addr_ok && !i_hwrite && addr_ofs == OFS_DATA && rxf_cnt_reg != '0;
  assign wr_now  = wr_pend_reg;
  assign tx_push = wr_now && wr_addr_reg == OFS_DATA && txf_cnt_reg != DEPTH[AW:0]
                   && !cfg_txf_rst;

  // Pin synchronisers, two flops before any reader
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      rxd_sync_reg <= 2'b11;
      cts_sync_reg <= 2'b00;
      dsr_sync_reg <= 2'b00;
    end else begin
      rxd_sync_reg <= {rxd_sync_reg[0], i_rxd};
      cts_sync_reg <= {cts_sync_reg[0], i_cts};
      dsr_sync_reg <= {dsr_sync_reg[0], i_dsr};
    end
  end

  // Internal line levels after inversion and loopback
  logic rx_line, cts_on, rts_on;
  assign rx_line = cfg_loop ? tx_line_reg
                            : rxd_sync_reg[1] ^ frame_cfg_reg[FC_RXD_INV];
  assign cts_on  = cts_sync_reg[1] ^ frame_cfg_reg[FC_CTS_INV];
  // Flow threshold overrides software request level
  assign rts_on  = frame_cfg_reg[FC_SW_REQ]
                   && !(thresh_cfg_reg[TC_RX_FLOW_EN]
                        && rxf_cnt_reg >= {1'b0, thr_flow});

  // Configuration registers written in the data phase
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      frame_cfg_reg  <= FC_RESET;
      thresh_cfg_reg <= TC_RESET;
      baud_div_reg   <= BAUD_DIV_RESET;
    end else if (wr_now) begin
      case (wr_addr_reg)
        OFS_FRAME_CFG:  frame_cfg_reg  <= i_hwdata & FC_MASK;
        OFS_THRESH_CFG: thresh_cfg_reg <= i_hwdata & TC_MASK;
        // Divider below two would stall the half-bit timing
        OFS_BAUD_DIV:   baud_div_reg   <= (i_hwdata[15:0] < BAUD_DIV_MIN) ? BAUD_DIV_MIN
                                                                          : i_hwdata[15:0];
        default: ;
      endcase
    end
  end

  // Bus handshake and read data, captured at the address phase
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      o_hrdata    <= '0;
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
    end else begin
      wr_pend_reg <= addr_ok && i_hwrite;
      wr_addr_reg <= addr_ofs;
      o_hrdata    <= '0;
      if (addr_ok && !i_hwrite) begin
        case (addr_ofs)
          OFS_PORT_STATUS: begin
            o_hrdata[ST_RTS]            <= o_software_request_line;
            o_hrdata[ST_DTR]            <= o_dtr;
            o_hrdata[ST_TXCNT_LO +: 8]  <= 8'(txf_cnt_reg);
            o_hrdata[ST_RXD]            <= rxd_sync_reg[1];
            o_hrdata[ST_CTS]            <= cts_sync_reg[1];
            o_hrdata[ST_DSR]            <= dsr_sync_reg[1];
            o_hrdata[ST_RXCNT_LO +: 8]  <= 8'(rxf_cnt_reg);
          end
          OFS_FRAME_CFG:    o_hrdata <= frame_cfg_reg;
          OFS_THRESH_CFG:   o_hrdata <= thresh_cfg_reg;
          OFS_LOW_PULSE:    o_hrdata <= {12'h000, low_min_reg};
          OFS_DATA:         o_hrdata <= (rxf_cnt_reg != '0) ? 32'(rxf_mem[rxf_rp_reg]) : '0;
          OFS_EVENT_STATUS: o_hrdata <= {26'h000_0000, event_reg};
          OFS_BAUD_DIV:     o_hrdata <= {16'h0000, baud_div_reg};
          default:          o_hrdata <= '0;
        endcase
      end
    end
  end

  // Transmit FIFO; reset bit holds it empty as a level
  logic tx_pop;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn || cfg_txf_rst) begin
      txf_wp_reg  <= '0;
      txf_rp_reg  <= '0;
      txf_cnt_reg <= '0;
    end else begin
      if (tx_push) begin
        txf_mem[txf_wp_reg] <= i_hwdata[DW-1:0];
        txf_wp_reg          <= txf_wp_reg + 1'b1;
      end
      if (tx_pop) txf_rp_reg <= txf_rp_reg + 1'b1;
      txf_cnt_reg <= txf_cnt_reg + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    end
  end

  // Receive FIFO; a full FIFO drops the new character
  logic rx_push;
  logic [DW-1:0] rx_word;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn || cfg_rxf_rst) begin
      rxf_wp_reg  <= '0;
      rxf_rp_reg  <= '0;
      rxf_cnt_reg <= '0;
    end else begin
      if (rx_push) begin
        rxf_mem[rxf_wp_reg] <= rx_word;
        rxf_wp_reg          <= rxf_wp_reg + 1'b1;
      end
      if (rd_pop) rxf_rp_reg <= rxf_rp_reg + 1'b1;
      rxf_cnt_reg <= rxf_cnt_reg + (AW+1)'(rx_push) - (AW+1)'(rd_pop);
    end
  end

  // Stop length in half-bit steps
  logic [2:0]  stop_halves;
  logic [15:0] half_div;
  assign stop_halves = (cfg_stop == STOP_TWO)      ? HALVES_TWO
                     : (cfg_stop == STOP_ONE_HALF) ? HALVES_ONE_HALF : HALVES_ONE;
  assign half_div    = {1'b0, baud_div_reg[15:1]};

  // Parity bit of a character: even makes total ones even
  function automatic logic par_of(input logic [DW-1:0] d, input logic [3:0] n,
                                  input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < DW; i++) begin
      if (i < int'(n)) p = p ^ d[i];
    end
    return p;
  endfunction : par_of

  // Transmitter; start only when CTS allows
  assign tx_pop = tx_state_reg == FR_IDLE && txf_cnt_reg != '0
                  && (!frame_cfg_reg[FC_TX_FLOW_EN] || cts_on);
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      tx_state_reg <= FR_IDLE;
      tx_tmr_reg   <= '0;
      tx_bit_reg   <= '0;
      tx_shift_reg <= '0;
      tx_line_reg  <= 1'b1;
    end else if (tx_state_reg != FR_IDLE && tx_tmr_reg != '0) begin
      tx_tmr_reg <= tx_tmr_reg - 1'b1;
    end else begin
      case (tx_state_reg)
        FR_IDLE: begin
          if (tx_pop) begin
            tx_shift_reg <= txf_mem[txf_rp_reg];
            tx_line_reg  <= 1'b0;
            tx_tmr_reg   <= baud_div_reg - 1'b1;
            tx_state_reg <= FR_START;
          end
        end
        FR_START, FR_DATA: begin
          tx_tmr_reg <= baud_div_reg - 1'b1;
          if (tx_state_reg == FR_START || tx_bit_reg != cfg_nbits) begin
            tx_line_reg  <= tx_shift_reg[tx_bit_reg[2:0]];
            tx_bit_reg   <= tx_bit_reg + 1'b1;
            tx_state_reg <= FR_DATA;
          end else if (cfg_par_en) begin
            tx_line_reg  <= par_of(tx_shift_reg, cfg_nbits, cfg_par_odd);
            tx_state_reg <= FR_PARITY;
          end else begin
            tx_line_reg  <= 1'b1;
            tx_tmr_reg   <= half_div - 1'b1;
            tx_bit_reg   <= {1'b0, stop_halves} - 1'b1;
            tx_state_reg <= FR_STOP;
          end
        end
        FR_PARITY: begin
          tx_line_reg  <= 1'b1;
          tx_tmr_reg   <= half_div - 1'b1;
          tx_bit_reg   <= {1'b0, stop_halves} - 1'b1;
          tx_state_reg <= FR_STOP;
        end
        FR_STOP: begin
          if (tx_bit_reg != '0) begin
            tx_bit_reg <= tx_bit_reg - 1'b1;
            tx_tmr_reg <= half_div - 1'b1;
          end else begin
            tx_state_reg <= FR_IDLE;
          end
        end
        default: tx_state_reg <= FR_IDLE;
      endcase
    end
  end

  // Receiver, samples mid-bit
  logic rx_par_bad, rx_frm_bad, rx_ovr;
  assign rx_word = rx_shift_reg >> (4'(DW) - cfg_nbits);
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      rx_state_reg <= FR_IDLE;
      rx_tmr_reg   <= '0;
      rx_bit_reg   <= '0;
      rx_shift_reg <= '0;
      rx_push      <= 1'b0;
      rx_par_bad   <= 1'b0;
      rx_frm_bad   <= 1'b0;
      rx_ovr       <= 1'b0;
    end else begin
      rx_push    <= 1'b0;
      rx_par_bad <= 1'b0;
      rx_frm_bad <= 1'b0;
      rx_ovr     <= 1'b0;
      if (rx_state_reg != FR_IDLE && rx_tmr_reg != '0) begin
        rx_tmr_reg <= rx_tmr_reg - 1'b1;
      end else begin
        case (rx_state_reg)
          FR_IDLE: begin
            if (!rx_line) begin
              rx_tmr_reg   <= half_div - 1'b1;
              rx_bit_reg   <= '0;
              rx_state_reg <= FR_START;
            end
          end
          FR_START: begin
            rx_tmr_reg   <= baud_div_reg - 1'b1;
            rx_state_reg <= rx_line ? FR_IDLE : FR_DATA; // Glitch, not a start
          end
          FR_DATA: begin
            rx_tmr_reg   <= baud_div_reg - 1'b1;
            rx_shift_reg <= {rx_line, rx_shift_reg[DW-1:1]};
            rx_bit_reg   <= rx_bit_reg + 1'b1;
            if (rx_bit_reg + 1'b1 == cfg_nbits)
              rx_state_reg <= cfg_par_en ? FR_PARITY : FR_STOP;
          end
          FR_PARITY: begin
            rx_tmr_reg   <= baud_div_reg - 1'b1;
            rx_par_bad   <= rx_line != par_of(rx_word, cfg_nbits, cfg_par_odd);
            rx_state_reg <= FR_STOP;
          end
          FR_STOP: begin
            // Only the first stop bit is checked; the rest is idle time
            rx_frm_bad   <= !rx_line;
            rx_push      <= rx_line && rxf_cnt_reg != DEPTH[AW:0] && !cfg_rxf_rst;
            rx_ovr       <= rx_line && rxf_cnt_reg == DEPTH[AW:0];
            rx_state_reg <= FR_IDLE;
          end
          default: rx_state_reg <= FR_IDLE;
        endcase
      end
    end
  end

  // Shortest low pulse in clock cycles; any write to the register rearms it
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      rx_line_prev_reg <= 1'b1;
      low_run_reg      <= '0;
      low_min_reg      <= LOW_PULSE_RESET;
    end else begin
      rx_line_prev_reg <= rx_line;
      if (!rx_line) low_run_reg <= (low_run_reg == LOW_PULSE_RESET) ? low_run_reg
                                                                    : low_run_reg + 1'b1;
      else low_run_reg <= '0;
      if (wr_now && wr_addr_reg == OFS_LOW_PULSE) low_min_reg <= LOW_PULSE_RESET;
      else if (rx_line && !rx_line_prev_reg && low_run_reg < low_min_reg)
        low_min_reg <= low_run_reg;
    end
  end

  // Idle time counted in character times while data waits
  logic line_busy;
  assign line_busy = rx_state_reg != FR_IDLE || !rx_line;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn || line_busy || rxf_cnt_reg == '0) begin
      idle_tmr_reg  <= '0;
      idle_bit_reg  <= '0;
      idle_char_reg <= '0;
    end else if (idle_tmr_reg + 1'b1 < baud_div_reg) begin
      idle_tmr_reg <= idle_tmr_reg + 1'b1;
    end else begin
      idle_tmr_reg <= '0;
      if (idle_bit_reg + 1'b1 < CHAR_BITS) begin
        idle_bit_reg <= idle_bit_reg + 1'b1;
      end else begin
        idle_bit_reg <= '0;
        if (idle_char_reg != '1) idle_char_reg <= idle_char_reg + 1'b1;
      end
    end
  end

  // Sticky events, write one to clear; a new event wins over the clear
  logic [5:0] ev_now, ev_clr;
  assign ev_now = {rx_ovr, rx_frm_bad, rx_par_bad, o_rx_timeout,
                   o_rx_nearly_full, o_tx_nearly_empty};
  assign ev_clr = (wr_now && wr_addr_reg == OFS_EVENT_STATUS) ? i_hwdata[5:0] : '0;
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) event_reg <= '0;
    else         event_reg <= (event_reg & ~ev_clr) | ev_now;
  end

  // Pin and level outputs, all registered
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      o_txd                   <= 1'b1;
      o_software_request_line <= 1'b0;
      o_dtr                   <= 1'b0;
      o_tx_nearly_empty       <= 1'b0;
      o_rx_nearly_full        <= 1'b0;
      o_rx_timeout            <= 1'b0;
    end else begin
      o_txd                   <= (tx_line_reg && !frame_cfg_reg[FC_TX_BREAK])
                                 ^ frame_cfg_reg[FC_TXD_INV];
      o_software_request_line <= rts_on ^ frame_cfg_reg[FC_RTS_INV];
      o_dtr                   <= frame_cfg_reg[FC_SW_DTR]
                                 ^ frame_cfg_reg[FC_DTR_INV];
      o_tx_nearly_empty       <= txf_cnt_reg <= {1'b0, thr_tx_empty};
      o_rx_nearly_full        <= rxf_cnt_reg >= {1'b0, thr_rx_full};
      o_rx_timeout            <= thresh_cfg_reg[TC_TOUT_EN] && rxf_cnt_reg != '0
                                 && !line_busy && idle_char_reg >= thr_tout;
    end
  end

endmodule : uart_frame_config_status

// ===== bench/uart_frame_config_status_chk.sv
// Port-level assertions for the serial port configuration block
module uart_frame_config_status_chk (
  input wire logic        i_clk_sys,
  input wire logic        i_rstn,
  input wire logic        i_hsel,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic        o_hreadyout,
  input wire logic        o_hresp,
  input wire logic        o_txd,
  input wire logic        o_software_request_line,
  input wire logic        o_dtr,
  input wire logic        o_tx_nearly_empty
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       take;
  logic       wr_seen;
  logic [2:0] since_wr;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  assign take = i_hsel && i_htrans == 2'h2 && i_hready;
  // Age of last write, saturating; dtr may only move shortly after one
  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      since_wr <= 3'h7;
      wr_seen  <= 1'b0;
    end else if (take && i_hwrite) begin
      since_wr <= 3'h0;
      wr_seen  <= 1'b1;
    end else if (since_wr != 3'h7) begin
      since_wr <= since_wr + 3'h1;
    end
  end
  chk_resp_okay: assert property (o_hresp == 1'b0) else $error("bad response");
  chk_zero_wait: assert property (o_hreadyout) else $error("wait state");
  chk_rdata_idle: assert property (!(take && !i_hwrite) |=> o_hrdata == 32'h0000_0000)
    else $error("read data outside data phase");
  chk_reset_pins: assert property ($rose(i_rstn) |-> o_txd && !o_dtr && !o_software_request_line)
    else $error("pins not idle after reset");
  chk_empty_after_rst: assert property ($rose(i_rstn) |-> ##[1:2] o_tx_nearly_empty)
    else $error("nearly empty missing");
  chk_dtr_moves: assert property ($changed(o_dtr) |-> since_wr <= 3'h4)
    else $error("dtr moved without write");
  chk_txd_needs_write: assert property (!o_txd |-> wr_seen)
    else $error("txd active with nothing sent");
  chk_start_bit_len: assert property ($fell(o_txd) |=> !o_txd)
    else $error("start bit too short");
endmodule : uart_frame_config_status_chk

// ===== bench/uart_remote.sv
// Remote serial station driving the port's receive and modem pins
module uart_remote #(
  parameter int BIT_CYC = 4
) (
  input  wire logic i_clk_sys,
  output logic      o_rxd,
  output logic      o_cts,
  output logic      o_dsr
);
  timeunit 1ns;
  timeprecision 1ns;
  // Line idles high, modem lines asserted
  initial begin
    o_rxd = 1'b1;
    o_cts = 1'b1;
    o_dsr = 1'b1;
  end
  task automatic flow(input logic c);
    o_cts <= c;
  endtask : flow
  // Five-bit frame with parity; call just after a clock edge
  task automatic send(input logic [7:0] d, input logic odd, input int halves);
    int i;
    o_rxd <= 1'b0;
    repeat (BIT_CYC) @(posedge i_clk_sys);
    for (i = 0; i < 5; i++) begin
      o_rxd <= d[i];
      repeat (BIT_CYC) @(posedge i_clk_sys);
    end
    o_rxd <= ^d[4:0] ^ odd;
    repeat (BIT_CYC) @(posedge i_clk_sys);
    o_rxd <= 1'b1;
    repeat (BIT_CYC * halves / 2) @(posedge i_clk_sys);
  endtask : send
endmodule : uart_remote

// ===== bench/uart_frame_config_status_tb.sv
// Self-checking bench for the serial port configuration block
module uart_frame_config_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import uart_cfg_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  logic        i_clk_sys = 1'b0;
  logic        i_rstn = 1'b0;
  logic        i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0000_0000;
  logic [1:0]  i_htrans = 2'h0;
  logic        i_hwrite = 1'b0;
  logic [2:0]  i_hsize = 3'h2;
  logic [31:0] i_hwdata = 32'h0000_0000;
  logic [31:0] o_hrdata, r;
  logic        o_hreadyout, o_hresp, o_txd, o_software_request_line, o_dtr;
  logic        o_tx_nearly_empty, o_rx_nearly_full, o_rx_timeout, i_rxd, i_cts, i_dsr;
  logic        dph = 1'b0;
  wire         i_hready = o_hreadyout;
  logic [31:0] exp_q[$], msk_q[$];
  int          miscompares = 0;
  int          total_checks = 0;
  always #50 i_clk_sys = ~i_clk_sys;
  uart_frame_config_status uart_frame_config_status_inst (.*);
  uart_remote #(.BIT_CYC(4)) uart_remote_inst (.i_clk_sys(i_clk_sys), .o_rxd(i_rxd),
    .o_cts(i_cts), .o_dsr(i_dsr));
  // Address phase, then data phase, each held until hready is sampled high
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    i_haddr  <= {24'h00_0000, a};
    i_hwrite <= w;
    i_htrans <= HTRANS_NONSEQ;
    do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'h0;
    i_hwdata <= d;
    do @(posedge i_clk_sys); while (o_hreadyout !== 1'b1);
  endtask : bus
  // Idle gap first, so a preceding write has reached the pins
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    repeat (3) @(posedge i_clk_sys);
    bus(a, 1'b0, 32'h0000_0000);
  endtask : rd
  // Watcher: oldest note compared whenever read data stands
  always @(posedge i_clk_sys) begin
    if (dph) begin
      total_checks++;
      if ((o_hrdata & msk_q[0]) !== exp_q[0]) begin
        miscompares++;
        $display("[ERR] hrdata exp %h got %h", exp_q[0], o_hrdata & msk_q[0]);
      end
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    dph <= i_hsel && i_htrans == HTRANS_NONSEQ && !i_hwrite && o_hreadyout;
  end
  // Receive level pins, only looked at while they have long been steady
  task automatic lvl(input logic [1:0] e);
    total_checks++;
    if ({o_rx_nearly_full, o_rx_timeout} !== e) begin
      miscompares++;
      $display("[ERR] rx_levels exp %b got %b", e, {o_rx_nearly_full, o_rx_timeout});
    end
  endtask : lvl
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6000) @(posedge i_clk_sys);
    miscompares++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h51ea));
    repeat (4) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    i_hsel <= 1'b1;
    @(posedge i_clk_sys);
    rd(OFS_FRAME_CFG, FC_RESET, ALL);
    rd(OFS_THRESH_CFG, TC_RESET, ALL);
    rd(OFS_LOW_PULSE, {12'h000, LOW_PULSE_RESET}, ALL);
    rd(8'h40, 32'h0000_0000, ALL);
    rd(OFS_PORT_STATUS, 32'h0000_0000, 32'h00FF_00FF);
    bus(OFS_BAUD_DIV, 1'b1, 32'h0000_0004);
    bus(OFS_FRAME_CFG, 1'b1, 32'h0000_00D0);
    rd(OFS_PORT_STATUS, 32'h6000_E000, 32'h6000_E000);
    bus(OFS_FRAME_CFG, 1'b1, 32'h0180_00D0);
    rd(OFS_PORT_STATUS, 32'h0000_0000, 32'h6000_0000);
    r = {24'h00_0000, 8'($urandom)};
    bus(OFS_FRAME_CFG, 1'b1, 32'h0000_401E);
    bus(OFS_DATA, 1'b1, r);
    repeat (80) @(posedge i_clk_sys);
    rd(OFS_DATA, r, 32'h0000_00FF);
    rd(OFS_EVENT_STATUS, 32'h0000_0000, 32'h0000_0018);
    bus(OFS_FRAME_CFG, 1'b1, 32'h0000_0033);
    bus(OFS_LOW_PULSE, 1'b1, 32'h0000_0000);
    uart_remote_inst.send(8'h0A, 1'b1, 4);
    repeat (10) @(posedge i_clk_sys);
    lvl(2'b00);
    bus(OFS_THRESH_CFG, 1'b1, 32'h8081_6001);
    rd(OFS_PORT_STATUS, 32'h0000_0001, 32'h0000_00FF);
    lvl(2'b11);
    rd(OFS_LOW_PULSE, 32'h0000_0000, 32'hFFFF_FFF8);
    rd(OFS_EVENT_STATUS, 32'h0000_0000, 32'h0000_0018);
    rd(OFS_DATA, 32'h0000_000A, 32'h0000_00FF);
    uart_remote_inst.send(8'h15, 1'b1, 4);
    bus(OFS_FRAME_CFG, 1'b1, 32'h0002_0033);
    rd(OFS_PORT_STATUS, 32'h0000_0000, 32'h0000_00FF);
    uart_remote_inst.flow(1'b0);
    bus(OFS_FRAME_CFG, 1'b1, 32'h0000_8010);
    repeat (3) bus(OFS_DATA, 1'b1, {24'h00_0000, 8'($urandom)});
    repeat (40) @(posedge i_clk_sys);
    rd(OFS_PORT_STATUS, 32'h0003_0000, 32'h00FF_0000);
    bus(OFS_FRAME_CFG, 1'b1, 32'h0004_8010);
    rd(OFS_PORT_STATUS, 32'h0000_0000, 32'h00FF_0000);
    repeat (5) @(posedge i_clk_sys);
    print_verdict();
  end
endmodule : uart_frame_config_status_tb
bind uart_frame_config_status uart_frame_config_status_chk uart_frame_config_status_chk_inst (.*);
